// ---- hw/aid_defines.svh ----
// Register offsets, field positions, status codes and sizes of the decoder.
`ifndef AID_DEFINES_SVH
`define AID_DEFINES_SVH
`define AID_OFS_CMD 8'h00
`define AID_OFS_CDW10 8'h04
`define AID_OFS_CDW11 8'h08
`define AID_OFS_CDW14 8'h0C
`define AID_OFS_BUFPTR0 8'h10
`define AID_OFS_GO 8'h20
`define AID_OFS_CPL 8'h24
`define AID_OFS_CFG 8'h28
`define AID_OFS_LOGSUP 8'h2C
`define AID_OFS_IRQ_STAT 8'h30
`define AID_OFS_IRQ_MASK 8'h34
`define AID_OFS_DEC 8'h38
`define AID_OFS_SETID 8'h3C
`define AID_RST_WORD 32'h0000_0000
`define AID_SEL_RANGE 7:0
`define AID_CTLID_RANGE 31:16
`define AID_SETID_RANGE 15:0
`define AID_UUID_RANGE 6:0
`define AID_OPC_RANGE 7:0
`define AID_CID_RANGE 31:16
`define AID_CFG_NSMGMT 0
`define AID_CFG_SETLIST 1
`define AID_CFG_UUID 2
`define AID_CFG_LEGACY 3
`define AID_SEL_SETLIST 8'h04
`define AID_SEL_LAST_BASE 8'h03
`define AID_SEL_NSM_FIRST 8'h10
`define AID_SEL_CTLID_FIRST 8'h12
`define AID_SEL_NSM_LAST 8'h15
`define AID_SEL_UUID_LIST 8'h17
`define AID_SCT_GENERIC 3'h0
`define AID_SCT_CMD_SPEC 3'h1
`define AID_SC_SUCCESS 8'h00
`define AID_SC_INVALID_FIELD 8'h02
`define AID_SC_INVALID_LOG 8'h09
`define AID_STRUCT_BYTES 4096
`define AID_STRUCT_WORDS (`AID_STRUCT_BYTES / 4)
`endif

// ---- hw/aid_pkg.sv ----
// Types shared by the command decoder modules.
package aid_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DECODE,
		ST_XFER,
		ST_CPL
	} aid_state_t;
endpackage

// ---- hw/aid_if.sv ----
// Carriers between the decoder core, its bus slave and its copy engine.
`timescale 1ns/1ps
`default_nettype none
interface aid_reg_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic rd_en;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	modport slave(output wr_en, wr_addr, wr_data, rd_en, rd_addr,
		input rd_data);
	modport regs(input wr_en, wr_addr, wr_data, rd_en, rd_addr,
		output rd_data);
endinterface

interface aid_xfer_if;
	logic start;
	logic [63:0] base;
	logic [10:0] fill;
	logic done;
	modport ctrl(output start, base, fill, input done);
	modport eng(input start, base, fill, output done);
endinterface
`default_nettype wire

// ---- hw/aid_ahb_slave.sv ----
// AHB-Lite slave front end with zero wait states.
`include "aid_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module aid_ahb_slave
	import aid_pkg::*;
(
	input wire logic core_clk, // clock
	input wire logic reset, // synchronous reset
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write
	input wire logic [2:0] hsize, // size, words only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic [31:0] hrdata, // read data
	output logic hresp, // response
	aid_reg_if.slave rb // register side
);
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic hreadyout_ff;
	logic hresp_ff;
	logic [31:0] hrdata_ff;
	wire take = hsel & htrans[1] & hready;

	// Read data is sampled in the address phase so hrdata leaves a flop.
	assign rb.rd_en = take & ~hwrite;
	assign rb.rd_addr = haddr[7:0];
	assign rb.wr_en = wr_pend_ff;
	assign rb.wr_addr = wr_addr_ff;
	assign rb.wr_data = hwdata;
	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;
	assign hrdata = hrdata_ff;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
			hrdata_ff <= `AID_RST_WORD;
		end else begin
			wr_pend_ff <= take & hwrite;
			if (take)
				wr_addr_ff <= haddr[7:0];
			if (rb.rd_en)
				hrdata_ff <= rb.rd_data;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_ready_okay: assert property (hreadyout && !hresp)
		else $error("slave must stay ready with an OKAY answer");
	chk_write_strobe: assert property (take && hwrite |=> rb.wr_en
		&& rb.wr_addr == $past(haddr[7:0]))
		else $error("write data phase not strobed");
endmodule
`default_nettype wire

// ---- hw/aid_stream.sv ----
// Copy engine that writes one fixed-size structure into the host buffer.
`include "aid_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module aid_stream
	import aid_pkg::*;
#(
	parameter int WORDS = `AID_STRUCT_WORDS
) (
	input wire logic core_clk, // clock
	input wire logic reset, // synchronous reset
	aid_xfer_if.eng x, // start and done
	output logic buf_wr_valid, // buffer word valid
	input wire logic buf_wr_ready, // buffer accepts word
	output logic [63:0] buf_wr_addr, // host byte address
	output logic [31:0] buf_wr_data, // buffer word
	output logic [9:0] content_index, // word asked of builder
	input wire logic [31:0] content_data // builder word at index
);
	logic active_ff;
	logic [10:0] cnt_ff;
	logic [10:0] idx_ff;
	logic [10:0] fill_ff;
	logic [10:0] beats_ff;
	logic [63:0] base_ff;
	logic valid_ff;
	logic [63:0] addr_ff;
	logic [31:0] data_ff;
	logic done_ff;
	wire accept = valid_ff & buf_wr_ready;
	wire load = active_ff & (~valid_ff | buf_wr_ready)
		& (cnt_ff < 11'(WORDS));
	wire last = active_ff & accept & (cnt_ff == 11'(WORDS));
	wire [31:0] word = (cnt_ff < fill_ff) ? content_data : 32'h0000_0000;

	assign buf_wr_valid = valid_ff;
	assign buf_wr_addr = addr_ff;
	assign buf_wr_data = data_ff;
	assign content_index = cnt_ff[9:0];
	assign x.done = done_ff;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			active_ff <= 1'b0;
			cnt_ff <= 11'h000;
			idx_ff <= 11'h000;
			fill_ff <= 11'h000;
			beats_ff <= 11'h000;
			base_ff <= 64'h0000_0000_0000_0000;
			valid_ff <= 1'b0;
			addr_ff <= 64'h0000_0000_0000_0000;
			data_ff <= 32'h0000_0000;
			done_ff <= 1'b0;
		end else begin
			done_ff <= last;
			if (x.start) begin
				active_ff <= 1'b1;
				cnt_ff <= 11'h000;
				beats_ff <= 11'h000;
				fill_ff <= x.fill;
				base_ff <= x.base;
			end else begin
				if (last)
					active_ff <= 1'b0;
				if (accept)
					beats_ff <= beats_ff + 11'h001;
				if (load) begin
					valid_ff <= 1'b1;
					addr_ff <= base_ff + 64'({cnt_ff, 2'b00});
					data_ff <= word;
					idx_ff <= cnt_ff;
					cnt_ff <= cnt_ff + 11'h001;
				end else if (accept) begin
					valid_ff <= 1'b0;
				end
			end
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_zero_fill_tail: assert property (valid_ff && idx_ff >= fill_ff
		|-> data_ff == 32'h0000_0000)
		else $error("unused structure words not zero");
	chk_word_total: assert property (done_ff |-> beats_ff == 11'(WORDS))
		else $error("structure length not the full size");
	chk_hold_stall: assert property (valid_ff && !buf_wr_ready
		|=> valid_ff && $stable(data_ff) && $stable(addr_ff))
		else $error("buffer word changed while stalled");
endmodule
`default_nettype wire

// ---- hw/aid_core.sv ----
// Admin information and log-page command decoder with AHB-Lite registers.
// Function
// - Log-page command ends by posting exactly one completion entry.
// - Unsupported, invalid or reserved log page completes with code 9h.
// - Older-style controllers may report generic invalid field instead.
// - Information command with a supported selector returns exactly 4,096 bytes.
// - Only pointer and dwords 10, 11, 14 are read; rest reserved.
// - Dword 10 bits 31:16 hold controller identifier, used when needed.
// - Controller ignores the controller identifier when not used.
// - With namespace management, controller identifier is decoded for selectors 12h to 15h.
// - Selector is dword 10 bits 07:00; bits 15:08 reserved.
// - Set identifier is dword 11 bits 15:00, used for selector 04h.
// - UUID index read from dword 14 only if UUID selection supported.
// - UUID index is dword 14 bits 06:00; upper bits reserved.
// - Unsupported selector aborts with invalid field in command.
// - Unused tail of the returned structure is zero filled.
`include "aid_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module aid_core
	import aid_pkg::*;
#(
	parameter logic [7:0] OPC_INFO = 8'h06, // information command
	parameter logic [7:0] OPC_LOG = 8'h02 // log-page command
) (
	input wire logic core_clk, // clock
	input wire logic reset, // synchronous reset
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write
	input wire logic [2:0] hsize, // size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic [31:0] hrdata, // read data
	output logic hresp, // response
	output logic irq, // interrupt level
	output logic buf_wr_valid, // buffer word valid
	input wire logic buf_wr_ready, // buffer accepts word
	output logic [63:0] buf_wr_addr, // host byte address
	output logic [31:0] buf_wr_data, // buffer word
	output logic [9:0] content_index, // word asked of builder
	input wire logic [31:0] content_data, // builder word
	input wire logic [10:0] content_words, // words the builder holds
	output logic [7:0] info_selector, // decoded structure selector
	output logic [15:0] info_ctlid, // decoded controller identifier
	output logic [15:0] info_setid, // decoded set identifier
	output logic [6:0] info_uuid, // decoded UUID index
	output logic cpl_valid, // completion posted pulse
	output logic [15:0] cpl_cid, // completion command identifier
	output logic [10:0] cpl_status // completion type and code
);
	aid_reg_if rb();
	aid_xfer_if xf();

	aid_ahb_slave u_slave (
		.core_clk(core_clk),
		.reset(reset),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp),
		.rb(rb.slave)
	);

	aid_stream u_stream (
		.core_clk(core_clk),
		.reset(reset),
		.x(xf.eng),
		.buf_wr_valid(buf_wr_valid),
		.buf_wr_ready(buf_wr_ready),
		.buf_wr_addr(buf_wr_addr),
		.buf_wr_data(buf_wr_data),
		.content_index(content_index),
		.content_data(content_data)
	);

	////////////////////////////////////////////////////////////////////////
	aid_state_t state_ff;
	aid_state_t nxt_state;
	logic [31:0] cmd_ff;
	logic [31:0] cdw10_ff;
	logic [31:0] cdw11_ff;
	logic [31:0] cdw14_ff;
	logic [31:0] bufptr_ff [4];
	logic [3:0] cfg_ff;
	logic [31:0] logsup_ff;
	logic [1:0] irq_stat_ff;
	logic [1:0] irq_mask_ff;
	logic irq_ff;
	logic [10:0] status_ff;
	logic cpl_valid_ff;
	logic [15:0] cpl_cid_ff;
	logic [7:0] sel_ff;
	logic [15:0] ctlid_ff;
	logic [15:0] setid_ff;
	logic [6:0] uuid_ff;
	logic start_ff;
	logic xfer_seen_ff;

	wire wr = rb.wr_en;
	wire wr_cmd = wr & (rb.wr_addr == `AID_OFS_CMD);
	wire wr_cdw10 = wr & (rb.wr_addr == `AID_OFS_CDW10);
	wire wr_cdw11 = wr & (rb.wr_addr == `AID_OFS_CDW11);
	wire wr_cdw14 = wr & (rb.wr_addr == `AID_OFS_CDW14);
	wire wr_cfg = wr & (rb.wr_addr == `AID_OFS_CFG);
	wire wr_logsup = wr & (rb.wr_addr == `AID_OFS_LOGSUP);
	wire wr_mask = wr & (rb.wr_addr == `AID_OFS_IRQ_MASK);
	wire busy = state_ff != ST_IDLE;
	// A start while busy is dropped; command registers stay writable.
	wire go = wr & (rb.wr_addr == `AID_OFS_GO) & rb.wr_data[0] & ~busy;
	wire rd_stat = rb.rd_en & (rb.rd_addr == `AID_OFS_IRQ_STAT);

	// Decode of the latched command; reserved bits stay unread.
	wire [7:0] opc = cmd_ff[`AID_OPC_RANGE];
	wire is_info = opc == OPC_INFO;
	wire is_log = opc == OPC_LOG;
	wire [7:0] sel = cdw10_ff[`AID_SEL_RANGE];
	wire nsm = cfg_ff[`AID_CFG_NSMGMT];
	wire nsm_sel = (sel >= `AID_SEL_NSM_FIRST) & (sel <= `AID_SEL_NSM_LAST);
	wire ctlid_used = nsm & (sel >= `AID_SEL_CTLID_FIRST)
		& (sel <= `AID_SEL_NSM_LAST);
	wire set_sel = sel == `AID_SEL_SETLIST;
	wire sel_ok = (sel <= `AID_SEL_LAST_BASE)
		| (set_sel & cfg_ff[`AID_CFG_SETLIST])
		| (nsm & nsm_sel)
		| ((sel == `AID_SEL_UUID_LIST) & cfg_ff[`AID_CFG_UUID]);
	wire [7:0] log_id = cdw10_ff[7:0];
	wire page_ok = (log_id[7:5] == 3'h0) & logsup_ff[log_id[4:0]];
	wire [10:0] st_ok = {`AID_SCT_GENERIC, `AID_SC_SUCCESS};
	wire [10:0] st_field = {`AID_SCT_GENERIC, `AID_SC_INVALID_FIELD};
	wire [10:0] st_badlog = cfg_ff[`AID_CFG_LEGACY] ? st_field
		: {`AID_SCT_CMD_SPEC, `AID_SC_INVALID_LOG};
	wire [10:0] dec_status = (is_info & sel_ok) ? st_ok
		: is_info ? st_field
		: (is_log & page_ok) ? st_ok
		: is_log ? st_badlog : st_field;
	wire start_xfer = (state_ff == ST_DECODE) & is_info & sel_ok;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (go)
					nxt_state = ST_DECODE;
			end
			ST_DECODE: begin
				nxt_state = start_xfer ? ST_XFER : ST_CPL;
			end
			ST_XFER: begin
				if (xf.done)
					nxt_state = ST_CPL;
			end
			ST_CPL: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Read-to-clear status: a new event in the clearing cycle survives.
	wire [1:0] irq_set = {cpl_valid_ff & (status_ff != st_ok), cpl_valid_ff};
	wire [1:0] nxt_irq_stat = (irq_stat_ff & ~{2{rd_stat}}) | irq_set;

	assign rb.rd_data = (rb.rd_addr == `AID_OFS_CMD) ? cmd_ff
		: (rb.rd_addr == `AID_OFS_CDW10) ? cdw10_ff
		: (rb.rd_addr == `AID_OFS_CDW11) ? cdw11_ff
		: (rb.rd_addr == `AID_OFS_CDW14) ? cdw14_ff
		: (rb.rd_addr[7:4] == 4'h1) ? bufptr_ff[rb.rd_addr[3:2]]
		: (rb.rd_addr == `AID_OFS_GO) ? {31'h0000_0000, busy}
		: (rb.rd_addr == `AID_OFS_CPL) ? {cpl_cid_ff, 5'h00, status_ff}
		: (rb.rd_addr == `AID_OFS_CFG) ? {28'h000_0000, cfg_ff}
		: (rb.rd_addr == `AID_OFS_LOGSUP) ? logsup_ff
		: (rb.rd_addr == `AID_OFS_IRQ_STAT) ? {30'h0000_0000, irq_stat_ff}
		: (rb.rd_addr == `AID_OFS_IRQ_MASK) ? {30'h0000_0000, irq_mask_ff}
		: (rb.rd_addr == `AID_OFS_DEC) ? {ctlid_ff, 1'b0, uuid_ff, sel_ff}
		: (rb.rd_addr == `AID_OFS_SETID) ? {16'h0000, setid_ff}
		: `AID_RST_WORD;

	assign xf.start = start_ff;
	assign xf.base = {bufptr_ff[1], bufptr_ff[0]};
	assign xf.fill = content_words;
	assign irq = irq_ff;
	assign cpl_valid = cpl_valid_ff;
	assign cpl_cid = cpl_cid_ff;
	assign cpl_status = status_ff;
	assign info_selector = sel_ff;
	assign info_ctlid = ctlid_ff;
	assign info_setid = setid_ff;
	assign info_uuid = uuid_ff;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_bufptr
			wire wr_ptr = wr & (rb.wr_addr == `AID_OFS_BUFPTR0 + 8'(gi * 4));
			always_ff @(posedge core_clk) begin
				if (reset)
					bufptr_ff[gi] <= `AID_RST_WORD;
				else if (wr_ptr)
					bufptr_ff[gi] <= rb.wr_data;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cmd_ff <= `AID_RST_WORD;
			cdw10_ff <= `AID_RST_WORD;
			cdw11_ff <= `AID_RST_WORD;
			cdw14_ff <= `AID_RST_WORD;
			cfg_ff <= 4'h0;
			logsup_ff <= `AID_RST_WORD;
			irq_mask_ff <= 2'b00;
		end else begin
			if (wr_cmd)
				cmd_ff <= rb.wr_data;
			if (wr_cdw10)
				cdw10_ff <= rb.wr_data;
			if (wr_cdw11)
				cdw11_ff <= rb.wr_data;
			if (wr_cdw14)
				cdw14_ff <= rb.wr_data;
			if (wr_cfg)
				cfg_ff <= rb.wr_data[3:0];
			if (wr_logsup)
				logsup_ff <= rb.wr_data;
			if (wr_mask)
				irq_mask_ff <= rb.wr_data[1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ff <= ST_IDLE;
			start_ff <= 1'b0;
			status_ff <= 11'h000;
			cpl_valid_ff <= 1'b0;
			cpl_cid_ff <= 16'h0000;
			irq_stat_ff <= 2'b00;
			irq_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			start_ff <= start_xfer;
			if (state_ff == ST_DECODE)
				status_ff <= dec_status;
			cpl_valid_ff <= state_ff == ST_CPL;
			if (state_ff == ST_CPL)
				cpl_cid_ff <= cmd_ff[`AID_CID_RANGE];
			irq_stat_ff <= nxt_irq_stat;
			irq_ff <= |(nxt_irq_stat & irq_mask_ff);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sel_ff <= 8'h00;
			ctlid_ff <= 16'h0000;
			setid_ff <= 16'h0000;
			uuid_ff <= 7'h00;
		end else if (state_ff == ST_DECODE && is_info) begin
			sel_ff <= sel;
			ctlid_ff <= ctlid_used ? cdw10_ff[`AID_CTLID_RANGE] : 16'h0000;
			setid_ff <= set_sel ? cdw11_ff[`AID_SETID_RANGE] : 16'h0000;
			uuid_ff <= cfg_ff[`AID_CFG_UUID]
				? cdw14_ff[`AID_UUID_RANGE] : 7'h00;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			xfer_seen_ff <= 1'b0;
		else if (state_ff == ST_DECODE)
			xfer_seen_ff <= 1'b0;
		else if (xf.done)
			xfer_seen_ff <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_bad_log_code: assert property (state_ff == ST_DECODE && is_log
		&& !page_ok |=> ##1 cpl_valid && (cpl_status[7:0] == 8'h09
		|| cpl_status == 11'h002))
		else $error("bad log page not reported as invalid");
	chk_legacy_code: assert property (state_ff == ST_DECODE && is_log
		&& !page_ok && cfg_ff[3] |=> ##1 cpl_status == 11'h002)
		else $error("legacy log status not generic invalid field");
	chk_one_cpl: assert property (cpl_valid |=> !cpl_valid[*3])
		else $error("more than one completion for a command");
	chk_cpl_after_data: assert property (cpl_valid && is_info
		&& cpl_status == 11'h000 |-> xfer_seen_ff)
		else $error("completion before structure written");
	chk_bad_sel_abort: assert property (state_ff == ST_DECODE && is_info
		&& !sel_ok |=> ##1 cpl_valid && cpl_status == 11'h002 && !buf_wr_valid)
		else $error("unsupported selector not aborted");
	chk_ctlid_ignored: assert property (state_ff == ST_DECODE && is_info
		&& !ctlid_used |=> info_ctlid == 16'h0000)
		else $error("unused controller identifier leaked");
	chk_ctlid_taken: assert property (state_ff == ST_DECODE && is_info
		&& ctlid_used |=> info_ctlid == $past(cdw10_ff[31:16]))
		else $error("controller identifier not decoded");
	chk_setid_gate: assert property (state_ff == ST_DECODE && is_info
		|=> info_setid == ($past(sel) == 8'h04 ? $past(cdw11_ff[15:0])
		: 16'h0000))
		else $error("set identifier decode wrong");
	chk_uuid_gate: assert property (state_ff == ST_DECODE && is_info
		|=> info_uuid == ($past(cfg_ff[2]) ? $past(cdw14_ff[6:0]) : 7'h00))
		else $error("UUID index decode wrong");
	chk_sel_field: assert property (state_ff == ST_DECODE && is_info
		|=> info_selector == $past(cdw10_ff[7:0]))
		else $error("selector not taken from low byte");
	chk_irq_level: assert property (irq == $past(|(irq_stat_ff & irq_mask_ff)
		|| |(irq_set & irq_mask_ff)) || $past(rd_stat) || $past(wr_mask))
		else $error("interrupt level disagrees with status");
endmodule
`default_nettype wire

// ---- bench/aid_host_model.sv ----
// Host buffer and structure builder model that faces the copy engine.
`timescale 1ns/1ps
`default_nettype none
module aid_host_model (
	input wire logic core_clk, // clock
	input wire logic reset, // synchronous reset
	input wire logic [63:0] base, // buffer start
	input wire logic [10:0] words, // real content words
	input wire logic buf_wr_valid, // word valid
	output logic buf_wr_ready, // word accepted
	input wire logic [63:0] buf_wr_addr, // byte address
	input wire logic [31:0] buf_wr_data, // word
	input wire logic [9:0] content_index, // index asked
	output logic [31:0] content_data, // builder word
	output logic [15:0] n_words, // words accepted
	output logic [15:0] n_bad // words wrong
);
	logic [63:0] off;
	logic [63:0] prev_ff;
	logic [31:0] want;
	logic bad;
	assign content_data = {16'h5a5a, 6'h00, content_index};
	assign off = buf_wr_addr - base;
	// Words past the real content must arrive as zeros.
	assign want = ({1'b0, off[11:2]} < words) ?
		{16'h5a5a, 6'h00, off[11:2]} : 32'h0000_0000;
	// Address must stay in the page and climb one word at a time.
	assign bad = off[63:12] != 0 || off[1:0] != 0 || buf_wr_data !== want
		|| (off != 0 && buf_wr_addr != prev_ff + 64'h4);
	always_ff @(posedge core_clk) begin
		if (reset) begin
			buf_wr_ready <= 1'b0;
			n_words <= 16'h0000;
			n_bad <= 16'h0000;
			prev_ff <= 64'h0;
		end else begin
			// Random stalls exercise the held word while not ready.
			buf_wr_ready <= ($urandom % 4) != 0;
			if (buf_wr_valid && buf_wr_ready) begin
				n_words <= n_words + 16'h0001;
				prev_ff <= buf_wr_addr;
				if (bad)
					n_bad <= n_bad + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the admin command decoder.
`include "aid_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [15:0] cid;
		logic [10:0] st;
		logic [15:0] nw;
	} aid_exp_t;
	logic core_clk = 0;
	logic reset = 1;
	logic hsel = 0;
	logic [31:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic hwrite = 0;
	logic [31:0] hwdata = 0;
	logic [10:0] cwords = 0;
	logic [63:0] base = 0;
	logic [3:0] cfg = 0;
	logic [1:0] msk = 0;
	logic [15:0] expw = 0;
	wire logic hready;
	logic hreadyout, hresp, irq, buf_wr_valid, buf_wr_ready, cpl_valid;
	logic [31:0] hrdata, buf_wr_data, content_data;
	logic [63:0] buf_wr_addr;
	logic [9:0] content_index;
	logic [7:0] info_selector;
	logic [15:0] info_ctlid, info_setid, cpl_cid, nw, nb;
	logic [6:0] info_uuid;
	logic [10:0] cpl_status;
	aid_exp_t exq[$];
	int n_mismatch = 0;
	int total_checks = 0;
	int n_cpl = 0;
	assign hready = hreadyout;
	always #4 core_clk = ~core_clk;
	aid_core #(.OPC_INFO(8'h06), .OPC_LOG(8'h02)) uut (.core_clk(core_clk),
		.reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
		.buf_wr_valid(buf_wr_valid), .buf_wr_ready(buf_wr_ready),
		.buf_wr_addr(buf_wr_addr), .buf_wr_data(buf_wr_data),
		.content_index(content_index), .content_data(content_data),
		.content_words(cwords), .info_selector(info_selector),
		.info_ctlid(info_ctlid), .info_setid(info_setid),
		.info_uuid(info_uuid), .cpl_valid(cpl_valid), .cpl_cid(cpl_cid),
		.cpl_status(cpl_status));
	aid_host_model host (.core_clk(core_clk), .reset(reset), .base(base),
		.words(cwords), .buf_wr_valid(buf_wr_valid),
		.buf_wr_ready(buf_wr_ready), .buf_wr_addr(buf_wr_addr),
		.buf_wr_data(buf_wr_data), .content_index(content_index),
		.content_data(content_data), .n_words(nw), .n_bad(nb));
	////////////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge core_clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge core_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		ahb(1'b1, a, d, v);
	endtask
	task rdc(input string what, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		ahb(1'b0, a, 32'h0000_0000, v);
		chk(what, v, e);
	endtask
	// One command end to end, with its completion and interrupt.
	task cmd(input logic [7:0] opc, input logic [31:0] c10, c11, c14,
		input logic [10:0] st, input logic [15:0] words);
		logic [31:0] v;
		logic [15:0] cid;
		int k;
		cid = $urandom;
		expw = expw + words;
		exq.push_back('{cid, st, expw});
		base <= {$urandom, 20'($urandom), 12'h000};
		cwords <= $urandom_range(1024, 0);
		wr(`AID_OFS_CMD, {cid, 8'h00, opc});
		wr(`AID_OFS_CDW10, c10);
		wr(`AID_OFS_CDW11, c11);
		wr(`AID_OFS_CDW14, c14);
		wr(`AID_OFS_BUFPTR0, base[31:0]);
		wr(`AID_OFS_BUFPTR0 + 8'h04, base[63:32]);
		wr(`AID_OFS_BUFPTR0 + 8'h08, 32'h0000_0000);
		wr(`AID_OFS_BUFPTR0 + 8'h0C, 32'h0000_0000);
		k = n_cpl;
		wr(`AID_OFS_GO, 32'h0000_0001);
		for (int t = 0; t < 4000 && n_cpl == k; t++)
			@(posedge core_clk);
		chk("completion seen", n_cpl, k + 1);
		repeat (2) @(posedge core_clk);
		chk("irq", irq, msk[0]);
		ahb(1'b0, `AID_OFS_IRQ_STAT, 32'h0000_0000, v);
		chk("error status bit", v[1], st != 0);
		chk("any status bit", v[1] | v[0], 1'b1);
		repeat (2) @(posedge core_clk);
		chk("irq cleared", irq, 1'b0);
	endtask
	function automatic logic sup_f(input logic [7:0] s, input logic [3:0] c);
		return s <= 8'h03 || (s == 8'h04 && c[1]) || (s == 8'h17 && c[2])
			|| (s >= 8'h10 && s <= 8'h15 && c[0]);
	endfunction
	////////////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		aid_exp_t e;
		if (cpl_valid === 1'b1) begin
			if (exq.size() == 0)
				chk("unexpected completion", 1'b1, 1'b0);
			else begin
				e = exq.pop_front();
				chk("cpl_status", cpl_status, e.st);
				chk("cpl_cid", cpl_cid, e.cid);
				chk("buffer words", nw, e.nw);
			end
			n_cpl++;
		end
	end
	initial begin
		repeat (90000) @(posedge core_clk);
		n_mismatch++;
		wrap_up;
	end
	initial begin
		logic [7:0] sels[10];
		logic [7:0] lids[3];
		logic [31:0] c10, c11, c14;
		logic ok;
		sels = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h10, 8'h12, 8'h15, 8'h16,
			8'h17, 8'hff};
		lids = '{8'h02, 8'h05, 8'h28};
		void'($urandom(32'h8dcc6105));
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		chk("hresp", hresp, 1'b0);
		chk("hreadyout", hreadyout, 1'b1);
		chk("cpl_valid", cpl_valid, 1'b0);
		chk("info_selector", info_selector, 8'h00);
		rdc("unmapped", 8'h40, 32'h0000_0000);
		rdc("go idle", `AID_OFS_GO, 32'h0000_0000);
		msk = 2'b11;
		wr(`AID_OFS_IRQ_MASK, 32'h0000_0003);
		wr(`AID_OFS_LOGSUP, 32'h0000_0004);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			cfg = {i[0], 3'h0};
			wr(`AID_OFS_CFG, {28'h000_0000, cfg});
			cmd(8'h02, {24'h00_0000, lids[i / 2]}, 0, 0, (i / 2 == 0) ? 11'h000
				: (cfg[3] ? 11'h002 : 11'h109), 0);
		end
		msk = 2'b00;
		wr(`AID_OFS_IRQ_MASK, 32'h0000_0000);
		cmd(8'h7f, 0, 0, 0, 11'h002, 0);
		msk = 2'b11;
		wr(`AID_OFS_IRQ_MASK, 32'h0000_0003);
		$display("test log page done");
		for (int p = 0; p < 2; p++) begin
			cfg = p ? 4'h7 : 4'h0;
			wr(`AID_OFS_CFG, {28'h000_0000, cfg});
			foreach (sels[j]) begin
				ok = sup_f(sels[j], cfg);
				c10 = {(sels[j] >= 8'h12 && sels[j] <= 8'h15) ? 16'($urandom)
					: 16'h0000, 8'($urandom), sels[j]};
				c11 = {16'($urandom),
					sels[j] == 8'h04 ? 16'($urandom) : 16'h0000};
				c14 = $urandom;
				cmd(8'h06, c10, c11, c14, ok ? 11'h000 : 11'h002,
					ok ? 16'd1024 : 16'd0);
				if (ok) begin
					chk("info_selector", info_selector, sels[j]);
					chk("info_ctlid", info_ctlid, (cfg[0] && sels[j] >= 8'h12
						&& sels[j] <= 8'h15) ? c10[31:16] : 16'h0000);
					chk("info_setid", info_setid, (sels[j] == 8'h04)
						? c11[15:0] : 16'h0000);
					chk("info_uuid", info_uuid, cfg[2] ? c14[6:0]
						: 7'h00);
				end
			end
		end
		$display("test information done");
		chk("bad buffer words", nb, 16'h0000);
		wrap_up;
	end
endmodule
`default_nettype wire
